// ---- hdl/ctrl_port_master.sv ----
`timescale 1ns/1ps
`include "ctrl_port_defines.svh"

// Behaviour
// - slave port on two wires; this master keeps the link at or under 800 kHz.
// - data bits change only while clock is low, held steady through clock high.
// - every transaction opens with data falling while clock stays high.
// - 7-bit first byte: seven address bits then direction, high means read.
// - 10-bit: prefix 11110, two upper bits, direction; then low eight bits.
// - every byte travels most significant bit first.
// - on a missing write acknowledge the master ends with a stop.
// - first byte after a write address loads the register pointer.
// - read: write address, pointer, then address with read direction.
// - each address follows a start; on a read, pointer setup ends in repeated start.
// - last byte is followed by data rising while clock is high.
// - master keeps clocking after each acknowledge for further bytes.
module ctrl_port_master
#(
    parameter int QUARTER = `CP_QUARTER_CYCLES
)
(
    input  wire logic                  clk_sys,
    input  wire logic                  rst_b,
    input  wire logic                  req_valid,
    input  ctrl_port_pkg::cp_req_t     req,
    input  wire logic [7:0]            wr_byte,
    output logic                       req_ready,
    output logic                       wr_take,
    output ctrl_port_pkg::cp_resp_t    resp,
    output logic                       busy,
    input  wire logic                  internal_cpu_enable,
    output logic                       ctrl_port_clock,
    input  wire logic                  ctrl_port_data_in,
    output logic                       ctrl_port_data_out,
    output logic                       ctrl_port_data_oe_b
);

    localparam int QW = $clog2(QUARTER + 1);

    // ****************************************************************
    // pin inputs
    // ****************************************************************
    logic sda_sync;
    logic cpu_own;

    pin_sync #(.RST_VAL(`CP_RST_PIN_HIGH)) u_sync_data
    (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .pin     (ctrl_port_data_in),
        .level   (sda_sync)
    );

    pin_sync #(.RST_VAL(`CP_RST_PIN_LOW)) u_sync_cpu
    (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .pin     (internal_cpu_enable),
        .level   (cpu_own)
    );

    // ****************************************************************
    // state
    // ****************************************************************
    ctrl_port_pkg::step_t   step_q;
    ctrl_port_pkg::step_t   step_d;
    ctrl_port_pkg::cp_req_t req_q;
    logic [QW-1:0]          q_cnt_q;
    logic [1:0]             phase_q;
    logic [3:0]             bit_q;
    logic [7:0]             shift_q;
    logic [7:0]             remain_q;
    logic                   rd_phase_q;
    logic [7:0]             byte_d;

    // ****************************************************************
    // decode
    // ****************************************************************
    wire logic       tick_w     = busy && (q_cnt_q == QW'(QUARTER - 1));
    wire logic       slot_end_w = tick_w && (phase_q == 2'h3);
    wire logic [1:0] np_w       = phase_q + 2'h1;
    wire logic       is_rd_w    = (step_q == ctrl_port_pkg::ST_RDATA);
    wire logic       is_byte_w  = (step_q == ctrl_port_pkg::ST_ADDR_HI)
                                || (step_q == ctrl_port_pkg::ST_ADDR_LO)
                                || (step_q == ctrl_port_pkg::ST_PTR)
                                || (step_q == ctrl_port_pkg::ST_WDATA)
                                || is_rd_w;
    wire logic       is_cond_w  = (step_q == ctrl_port_pkg::ST_START)
                                || (step_q == ctrl_port_pkg::ST_RSTART);
    wire logic       is_stop_w  = (step_q == ctrl_port_pkg::ST_STOP);
    wire logic       is_ack_w   = (bit_q == `CP_ACK_BIT);
    wire logic       adv_w      = slot_end_w && (!is_byte_w || is_ack_w);
    wire logic       nack_w     = !is_rd_w && (sda_sync != `CP_ACK_LEVEL);
    wire logic       last_w     = (remain_q <= 8'h01);
    wire logic       accept_w   = req_valid && req_ready;
    wire logic       finish_w   = adv_w && is_stop_w;
    wire logic       dir_w      = rd_phase_q ? `CP_DIR_READ : `CP_DIR_WRITE;
    wire logic [7:0] addr_hi_w  = req_q.ten_bit
                                ? {`CP_TEN_BIT_PREFIX, req_q.dev_addr[9:8], dir_w}
                                : {req_q.dev_addr[6:0], dir_w};
    // data bit pull: msb first on send, ack on all but the last read byte
    wire logic       bit_pull_w = is_ack_w ? (is_rd_w && !last_w)
                                : (!is_rd_w && !shift_q[`CP_MSB]);
    wire logic       pull1_w    = is_byte_w ? bit_pull_w : is_stop_w;
    wire logic       upd_sda_w  = tick_w && ((np_w == 2'h1)
                                || ((np_w == 2'h3) && (is_cond_w || is_stop_w)));
    wire logic       pull_d     = (np_w == 2'h1) ? pull1_w : is_cond_w;

    // ****************************************************************
    // sequencer
    // ****************************************************************
    always_comb
    begin
        step_d = step_q;
        unique case (step_q)
            ctrl_port_pkg::ST_IDLE:
                step_d = ctrl_port_pkg::ST_IDLE;
            ctrl_port_pkg::ST_START:
                step_d = ctrl_port_pkg::ST_ADDR_HI;
            ctrl_port_pkg::ST_ADDR_HI:
                if (nack_w)
                    step_d = ctrl_port_pkg::ST_STOP;
                else if (rd_phase_q)
                    step_d = ctrl_port_pkg::ST_RDATA;
                else if (req_q.ten_bit)
                    step_d = ctrl_port_pkg::ST_ADDR_LO;
                else
                    step_d = ctrl_port_pkg::ST_PTR;
            ctrl_port_pkg::ST_ADDR_LO:
                step_d = nack_w ? ctrl_port_pkg::ST_STOP : ctrl_port_pkg::ST_PTR;
            ctrl_port_pkg::ST_PTR:
                if (nack_w)
                    step_d = ctrl_port_pkg::ST_STOP;
                else if (req_q.read)
                    step_d = ctrl_port_pkg::ST_RSTART;
                else if (remain_q == 8'h00)
                    step_d = ctrl_port_pkg::ST_STOP;
                else
                    step_d = ctrl_port_pkg::ST_WDATA;
            ctrl_port_pkg::ST_WDATA:
                step_d = (nack_w || last_w) ? ctrl_port_pkg::ST_STOP
                                            : ctrl_port_pkg::ST_WDATA;
            ctrl_port_pkg::ST_RSTART:
                step_d = ctrl_port_pkg::ST_ADDR_HI;
            ctrl_port_pkg::ST_RDATA:
                step_d = last_w ? ctrl_port_pkg::ST_STOP
                                : ctrl_port_pkg::ST_RDATA;
            ctrl_port_pkg::ST_STOP:
                step_d = ctrl_port_pkg::ST_IDLE;
        endcase
    end

    always_comb
    begin
        byte_d = `CP_RST_BYTE;
        unique case (step_d)
            ctrl_port_pkg::ST_ADDR_HI: byte_d = addr_hi_w;
            ctrl_port_pkg::ST_ADDR_LO: byte_d = req_q.dev_addr[7:0];
            ctrl_port_pkg::ST_PTR:     byte_d = req_q.pointer;
            ctrl_port_pkg::ST_WDATA:   byte_d = wr_byte;
            default:                   byte_d = `CP_RST_BYTE;
        endcase
    end

    // ****************************************************************
    // link clock divider
    // ****************************************************************
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            q_cnt_q <= '0;
        else if (!busy || tick_w)
            q_cnt_q <= '0;
        else
            q_cnt_q <= q_cnt_q + QW'(1);
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            phase_q <= 2'h0;
        else if (!busy)
            phase_q <= 2'h0;
        else if (tick_w)
            phase_q <= np_w;
    end

    // ****************************************************************
    // step, bit and byte tracking
    // ****************************************************************
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            step_q     <= ctrl_port_pkg::ST_IDLE;
            req_q      <= '0;
            rd_phase_q <= 1'b0;
        end
        else if (accept_w)
        begin
            step_q     <= ctrl_port_pkg::ST_START;
            req_q      <= req;
            rd_phase_q <= 1'b0;
        end
        else if (adv_w)
        begin
            step_q <= step_d;
            if (step_d == ctrl_port_pkg::ST_RSTART)
                rd_phase_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            bit_q <= 4'h0;
        else if (adv_w || accept_w)
            bit_q <= 4'h0;
        else if (slot_end_w && is_byte_w)
            bit_q <= bit_q + 4'h1;
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            shift_q <= `CP_RST_BYTE;
        else if (adv_w)
            shift_q <= byte_d;
        else if (slot_end_w && is_byte_w && !is_ack_w)
            shift_q <= {shift_q[6:0], is_rd_w ? sda_sync : 1'b0};
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            remain_q <= 8'h00;
        else if (accept_w)
            remain_q <= (req.read && (req.count == 8'h00)) ? 8'h01 : req.count;
        else if (adv_w && (step_q == ctrl_port_pkg::ST_WDATA || is_rd_w))
            remain_q <= remain_q - 8'h01;
    end

    // ****************************************************************
    // pins
    // ****************************************************************
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            ctrl_port_clock <= `CP_RST_PIN_HIGH;
        else if (tick_w && !(adv_w && step_d == ctrl_port_pkg::ST_IDLE))
            ctrl_port_clock <= np_w[1];
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctrl_port_data_oe_b <= `CP_RST_PIN_HIGH;
            ctrl_port_data_out  <= `CP_RST_PIN_LOW;
        end
        else if (upd_sda_w)
            ctrl_port_data_oe_b <= !pull_d;
    end

    // ****************************************************************
    // user side
    // ****************************************************************
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            busy      <= 1'b0;
            req_ready <= 1'b0;
        end
        else if (accept_w)
        begin
            busy      <= 1'b1;
            req_ready <= 1'b0;
        end
        else if (finish_w)
            busy <= 1'b0;
        else if (!busy)
            req_ready <= !cpu_own;
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            resp    <= '0;
            wr_take <= 1'b0;
        end
        else
        begin
            wr_take       <= adv_w && (step_d == ctrl_port_pkg::ST_WDATA);
            resp.done     <= finish_w;
            resp.rd_valid <= adv_w && is_rd_w;
            if (adv_w && is_rd_w)
                resp.rd_byte <= shift_q;
            if (accept_w)
                resp.nack <= 1'b0;
            else if (adv_w && is_byte_w && nack_w)
                resp.nack <= 1'b1;
        end
    end

endmodule

// ---- hdl/ctrl_port_defines.svh ----
`ifndef CTRL_PORT_DEFINES_SVH
`define CTRL_PORT_DEFINES_SVH

// ****************************************************************
// timing
// ****************************************************************
`define CP_SYS_PERIOD_NS        40
`define CP_LINK_MIN_PERIOD_NS   1250
// quarter of a link bit, rounded up so the link never beats 800 kHz
`define CP_QUARTER_CYCLES       ((`CP_LINK_MIN_PERIOD_NS + 4 * `CP_SYS_PERIOD_NS - 1) / (4 * `CP_SYS_PERIOD_NS))

// ****************************************************************
// byte layout
// ****************************************************************
`define CP_TEN_BIT_PREFIX       5'h1e
`define CP_DIR_READ             1'b1
`define CP_DIR_WRITE            1'b0
`define CP_ACK_BIT              4'h8
`define CP_ACK_LEVEL            1'b0
`define CP_MSB                  7

// ****************************************************************
// reset values
// ****************************************************************
`define CP_RST_PIN_HIGH         1'b1
`define CP_RST_PIN_LOW          1'b0
`define CP_RST_BYTE             8'h00

`endif

// ---- hdl/ctrl_port_pkg.sv ----
package ctrl_port_pkg;

    // ****************************************************************
    // request, answer and sequencer types
    // ****************************************************************
    typedef struct packed {
        logic       read;
        logic       ten_bit;
        logic [9:0] dev_addr;
        logic [7:0] pointer;
        logic [7:0] count;
    } cp_req_t;

    typedef struct packed {
        logic       done;
        logic       nack;
        logic       rd_valid;
        logic [7:0] rd_byte;
    } cp_resp_t;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_START,
        ST_ADDR_HI,
        ST_ADDR_LO,
        ST_PTR,
        ST_WDATA,
        ST_RSTART,
        ST_RDATA,
        ST_STOP
    } step_t;

endpackage

// ---- hdl/pin_sync.sv ----
`timescale 1ns/1ps
`include "ctrl_port_defines.svh"

// three stages; output moves once stages two and three agree
module pin_sync
#(
    parameter logic RST_VAL = `CP_RST_PIN_HIGH
)
(
    input  wire logic clk_sys,
    input  wire logic rst_b,
    input  wire logic pin,
    output logic      level
);

    logic s1_q;
    logic s2_q;
    logic s3_q;

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s1_q  <= RST_VAL;
            s2_q  <= RST_VAL;
            s3_q  <= RST_VAL;
            level <= RST_VAL;
        end
        else
        begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q)
            begin
                level <= s3_q;
            end
        end
    end

endmodule

// ---- verif/ctrl_port_assertions.sv ----
`timescale 1ns/1ps

// ********
// link checks
// ********
module ctrl_port_assertions
#(
    parameter int QUARTER = 8
)
(
    input wire logic               clk_sys,
    input wire logic               rst_b,
    input wire logic               req_valid,
    input wire logic               req_ready,
    input ctrl_port_pkg::cp_resp_t resp,
    input wire logic               busy,
    input wire logic               internal_cpu_enable,
    input wire logic               ctrl_port_clock,
    input wire logic               ctrl_port_data_out,
    input wire logic               ctrl_port_data_oe_b
);
    localparam int DMAX = 4 * QUARTER + 2;
    localparam int NMAX = 8 * QUARTER + 4;
    logic [15:0] hi_q;
    wire         clk_hi = ctrl_port_clock;
    wire         oe_b   = ctrl_port_data_oe_b;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    // cycles the link clock has been high
    always_ff @(posedge clk_sys or negedge rst_b)
        if (!rst_b)
            hi_q <= 16'hffff;
        else if (!clk_hi)
            hi_q <= 16'h0000;
        else if (hi_q != 16'hffff)
            hi_q <= hi_q + 16'h0001;

    property p_open_drain; ctrl_port_data_out == 1'b0; endproperty
    a_open_drain: assert property (p_open_drain) else $error("data driven high");
    property p_clk_high; $fell(clk_hi) |-> hi_q >= 2 * QUARTER; endproperty
    a_clk_high: assert property (p_clk_high) else $error("clock high too short");
    property p_apart; $changed(clk_hi) |-> $stable(oe_b); endproperty
    a_apart: assert property (p_apart) else $error("data moved with clock");
    property p_start; $fell(oe_b) && clk_hi && $past(clk_hi) |-> busy ##[1:DMAX] !clk_hi;
    endproperty
    a_start: assert property (p_start) else $error("bad start");
    property p_stop; $rose(oe_b) && clk_hi && $past(clk_hi) |-> ##[1:DMAX] resp.done;
    endproperty
    a_stop: assert property (p_stop) else $error("stop without done");
    property p_nack; $rose(resp.nack) |-> ##[1:NMAX] resp.done; endproperty
    a_nack: assert property (p_nack) else $error("nack not ended");
    property p_take; req_valid && req_ready |=> busy ##[0:NMAX] ($fell(oe_b) && clk_hi);
    endproperty
    a_take: assert property (p_take) else $error("no start after take");
    property p_cpu; internal_cpu_enable [*6] |-> !req_ready; endproperty
    a_cpu: assert property (p_cpu) else $error("ready while cpu owns bus");
    property p_idle; !busy |-> clk_hi && oe_b; endproperty
    a_idle: assert property (p_idle) else $error("lines not idle");
    property p_rd; resp.rd_valid |-> busy ##1 !resp.rd_valid; endproperty
    a_rd: assert property (p_rd) else $error("read pulse");

    c_read: cover property (resp.rd_valid);
    c_nack: cover property ($rose(resp.nack));
    c_take: cover property (req_valid && req_ready);
endmodule

bind ctrl_port_master ctrl_port_assertions #(.QUARTER(QUARTER)) u_chk (
    .clk_sys(clk_sys), .rst_b(rst_b), .req_valid(req_valid), .req_ready(req_ready),
    .resp(resp), .busy(busy), .internal_cpu_enable(internal_cpu_enable),
    .ctrl_port_clock(ctrl_port_clock), .ctrl_port_data_out(ctrl_port_data_out),
    .ctrl_port_data_oe_b(ctrl_port_data_oe_b));

// ---- verif/ctrl_port_slave_model.sv ----
`timescale 1ns/1ps

// ********
// slave register port
// ********
module ctrl_port_slave_model
(
    input wire logic ctrl_port_clock,
    input wire logic ctrl_port_data,
    input wire logic addr_width_select,
    input wire logic addr_select_low,
    input wire logic internal_cpu_enable,
    output logic     pull
);
    logic [7:0] regs [0:255];
    logic [7:0] sh    = 8'h00;
    logic [7:0] ptr   = 8'h00;
    logic       mine  = 1'b0;
    int         phase = 0;
    int         cnt   = 0;
    wire        wide  = addr_width_select;
    wire  [9:0] dev   = wide ? (addr_select_low ? 10'h276 : 10'h224)
                             : (addr_select_low ? 10'h06a : 10'h04a);
    wire        hi_ok = wide ? (sh[7:3] == 5'h1e && sh[2:1] == dev[9:8])
                             : (sh[7:1] == dev[6:0]);
    initial pull = 1'b0;

    always @(negedge ctrl_port_data)
        if (ctrl_port_clock)
        begin
            phase = 1;
            cnt = 0;
        end

    always @(posedge ctrl_port_data)
        if (ctrl_port_clock)
        begin
            phase = 0;
            mine = 1'b0;
        end

    always @(posedge ctrl_port_clock)
        if (cnt == 8)
        begin
            if (phase == 5 && ctrl_port_data)
                phase = 0;
            cnt = 0;
        end
        else
        begin
            sh = {sh[6:0], ctrl_port_data};
            cnt++;
        end

    always @(negedge ctrl_port_clock)
    begin
        pull = 1'b0;
        if (cnt == 8 && phase == 5)
            ptr = (ptr < 8'h06) ? ptr + 8'h01 : ptr;
        else if (cnt == 8 && phase != 0)
        begin
            case (phase)
                1: phase = !hi_ok ? 0 : !sh[0] ? (wide ? 2 : 3) : (wide && !mine) ? 0 : 5;
                2:
                begin
                    mine  = (sh == dev[7:0]);
                    phase = mine ? 3 : 0;
                end
                3:
                begin
                    ptr   = sh;
                    phase = 4;
                end
                4:
                begin
                    regs[ptr] = sh;
                    ptr       = (ptr < 8'h06) ? ptr + 8'h01 : ptr;
                end
                default: phase = 0;
            endcase
            if (internal_cpu_enable)
                phase = 0;
            pull = (phase != 0);
        end
        else if (phase == 5)
            pull = ~regs[ptr][7 - cnt];
    end
endmodule

// ---- verif/ctrl_port_master_tb.sv ----
`timescale 1ns/1ps

module ctrl_port_master_tb;
    localparam int QUARTER = 2;
    logic                    clk_sys = 1'b0;
    logic                    rst_b = 1'b0;
    logic                    req_valid = 1'b0;
    ctrl_port_pkg::cp_req_t  req = '0;
    logic [7:0]              wr_byte = 8'h00;
    logic                    cpu_en = 1'b0;
    logic                    w_sel = 1'b0;
    logic                    l_sel = 1'b0;
    logic                    req_ready, wr_take, busy, scl, m_out, m_oe_b, s_pull;
    ctrl_port_pkg::cp_resp_t resp;
    wire                     sda = ~((~m_oe_b & ~m_out) | s_pull);
    logic [7:0]              shadow [0:255];
    logic [7:0]              rd_q [$];
    logic                    nk_q [$];
    logic [31:0]             seed = 32'h0000_0001;
    int                      miscompares = 0;
    int                      num_checks = 0;
    int                      cycles = 0;
    logic [9:0]              addr_tab [0:3] = '{10'h04a, 10'h06a, 10'h224, 10'h276};

    initial forever #20 clk_sys = ~clk_sys;

    ctrl_port_master #(.QUARTER(QUARTER)) u_dut (.clk_sys(clk_sys), .rst_b(rst_b),
        .req_valid(req_valid), .req(req), .wr_byte(wr_byte), .req_ready(req_ready),
        .wr_take(wr_take), .resp(resp), .busy(busy), .internal_cpu_enable(cpu_en),
        .ctrl_port_clock(scl), .ctrl_port_data_in(sda), .ctrl_port_data_out(m_out),
        .ctrl_port_data_oe_b(m_oe_b));
    ctrl_port_slave_model u_slave (.ctrl_port_clock(scl), .ctrl_port_data(sda),
        .addr_width_select(w_sel), .addr_select_low(l_sel),
        .internal_cpu_enable(cpu_en), .pull(s_pull));

    function automatic logic [7:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict();
        if (miscompares == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // one whole transaction; expectations noted before it starts
    task automatic xfer(input logic r, input logic t, input logic [9:0] a,
                        input logic [7:0] p, input int n, input logic ok);
        logic [7:0] d [0:7];
        logic [7:0] q;
        int         m;
        q = p;
        m = (r && n == 0) ? 1 : n;
        d[0] = 8'h00;
        nk_q.push_back(~ok);
        for (int i = 0; i < m; i++)
        begin
            d[i] = xs();
            if (ok && r)
                rd_q.push_back(shadow[q]);
            if (ok && !r)
                shadow[q] = d[i];
            q = (q < 8'h06) ? q + 8'h01 : q;
        end
        @(negedge clk_sys);
        req = '{r, t, a, p, n[7:0]};
        wr_byte = d[0];
        req_valid = 1'b1;
        do @(posedge clk_sys); while (req_ready !== 1'b1);
        @(negedge clk_sys);
        req_valid = 1'b0;
        for (int i = 1; i < n && !r; i++)
        begin
            do @(posedge clk_sys); while (wr_take !== 1'b1);
            @(negedge clk_sys);
            wr_byte = d[i];
        end
        do @(posedge clk_sys); while (resp.done !== 1'b1);
    endtask

    always @(posedge clk_sys)
    begin
        cycles++;
        if (resp.rd_valid === 1'b1)
            check("rd_byte", resp.rd_byte, rd_q.pop_front());
        if (resp.done === 1'b1)
            check("nack", {7'h00, resp.nack}, {7'h00, nk_q.pop_front()});
        if (cycles == 20000)
        begin
            miscompares++;
            give_verdict();
        end
    end

    initial
    begin
        repeat (10) @(negedge clk_sys);
        rst_b = 1'b1;
        for (int k = 0; k < 4; k++)
        begin
            {w_sel, l_sel} = k[1:0];
            xfer(1'b0, k[1], addr_tab[k], 8'h01, 2, 1'b1);
            xfer(1'b1, k[1], addr_tab[k], 8'h01, 2, 1'b1);
            xfer(1'b0, k[1], addr_tab[k] ^ 10'h001, 8'h00, 1, 1'b0);
        end
        xfer(1'b0, 1'b1, 10'h276, 8'h05, 3, 1'b1);
        xfer(1'b1, 1'b1, 10'h276, 8'h05, 3, 1'b1);
        xfer(1'b0, 1'b1, 10'h276, 8'h02, 0, 1'b1);
        xfer(1'b1, 1'b1, 10'h276, 8'h05, 0, 1'b1);
        @(negedge clk_sys);
        cpu_en = 1'b1;
        repeat (8) @(negedge clk_sys);
        check("req_ready", {7'h00, req_ready}, 8'h00);
        cpu_en = 1'b0;
        repeat (8) @(negedge clk_sys);
        check("req_ready", {7'h00, req_ready}, 8'h01);
        check("rd_q left", 8'(rd_q.size()), 8'h00);
        check("nk_q left", 8'(nk_q.size()), 8'h00);
        give_verdict();
    end
endmodule
